// ---- bench/tb_usb_device_interrupt_flags.sv ----
// self-checking bench for the usb device interrupt flag block
module tb_usb_device_interrupt_flags;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_n, regWrite, regRead, queueEnable, idleReq, irqSeen;
  logic        busIdle, frameStartRx, busResetSeen, isoChecksumErr, inNoData, outNotReady;
  logic        stallSent, setupDone, queuePush, irqRequest, wakeAsync;
  logic [1:0]  irqLevel;
  logic [7:0]  regAddr, regWdata, regRdata, evReq, rdVal, w, enA, enB, flA, flB;
  logic [15:0] padTrim;
  int          nErrors, checksDone;
  logic [7:0]  rstAddr [9] = '{8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h3A, 8'h3B, 8'h55};

  udif_flags #(.SUSPEND_CNT(20)) i_dut (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .regAddr        (regAddr),
    .regWrite       (regWrite),
    .regRead        (regRead),
    .regWdata       (regWdata),
    .regRdata       (regRdata),
    .busIdle        (busIdle),
    .frameStartRx   (frameStartRx),
    .busResetSeen   (busResetSeen),
    .isoChecksumErr (isoChecksumErr),
    .inNoData       (inNoData),
    .outNotReady    (outNotReady),
    .stallSent      (stallSent),
    .setupDone      (setupDone),
    .queuePush      (queuePush),
    .queueEnable    (queueEnable),
    .irqLevel       (irqLevel),
    .irqRequest     (irqRequest),
    .wakeAsync      (wakeAsync),
    .padTrim        (padTrim)
  );
  udif_link_model i_link (
    .core_clk       (core_clk),
    .evReq          (evReq),
    .idleReq        (idleReq),
    .busIdle        (busIdle),
    .frameStartRx   (frameStartRx),
    .queuePush      (queuePush),
    .setupDone      (setupDone),
    .busResetSeen   (busResetSeen),
    .isoChecksumErr (isoChecksumErr),
    .inNoData       (inNoData),
    .outNotReady    (outNotReady),
    .stallSent      (stallSent)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ==========================================================
  // model and bus tasks
  function automatic logic irqExp();
    logic hit;
    hit = (flA[7] & enA[7]) | (|flA[6:4] & enA[6]) | (|flA[3:1] & enA[5]) | (flA[0] & enA[4]);
    return (enA[1:0] != 2'b00) && (hit || (|(flB[1:0] & enB[1:0])));
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp)
    begin
      nErrors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic r);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= r;
    @(negedge core_clk);
    rdVal   = regRdata;
    irqSeen = irqRequest;
    @(posedge core_clk);
    regRead <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a, 1'b0);
    chk($sformatf("reg_%h", a), {8'h00, e}, {8'h00, rdVal});
  endtask
  task automatic ev(input logic [7:0] m);
    @(posedge core_clk);
    evReq <= m;
    @(posedge core_clk);
    evReq <= 8'h00;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial
  begin
    {rst_n, regWrite, regRead, queueEnable, idleReq} = 5'h00;
    {regAddr, regWdata, evReq} = 24'h000000;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    void'($urandom(32'h0087));
    foreach (rstAddr[i]) rc(rstAddr[i], 8'h00);
    // each of the eight pulsed event lines once, with each level and random enables
    for (int b = 0; b < 8; b++)
    begin
      w = 8'($urandom);
      enA = {w[7:4], 2'b00, 2'(b)};
      enB = w & 8'h03;
      wr(8'h06, enA);
      wr(8'h07, enB);
      wr(8'h0A, 8'hFF);
      wr(8'h0C, 8'h03);
      wr(8'h04, 8'h00);
      ev(8'h01 << b);
      flA = (b == 5 || b == 6) ? 8'h00 : 8'h01 << b;
      flB = (b == 5) ? 8'h01 : (b == 6) ? 8'h02 : 8'h00;
      rc(8'h0B, flA);
      rc(8'h06, enA);
      rc(8'h07, enB);
      rc(8'h0D, flB);
      chk("irqRequest", {15'h0000, irqExp()}, {15'h0000, irqSeen});
      chk("irqLevel", {14'h0000, enA[1:0]}, {14'h0000, irqLevel});
    end
    repeat (3)
    begin
      w = 8'($urandom);
      wr(8'h0B, w);
      wr(8'h0D, w & 8'h03);
      flA |= w;
      flB |= w & 8'h03;
      rc(8'h0A, flA);
      rc(8'h0C, flB);
      w = 8'($urandom);
      wr(8'h0A, w);
      wr(8'h0C, w & 8'h03);
      flA &= ~w;
      flB &= ~w;
      rc(8'h0B, flA);
      rc(8'h0D, flB);
    end
    // completion queue: two entries drained by pointer reads, then a flush
    wr(8'h0C, 8'h03);
    queueEnable <= 1'b1;
    ev(8'h40);
    ev(8'h40);
    rd(8'h05, 1'b1);
    rc(8'h0C, 8'h02);
    rc(8'h05, 8'h01);
    rd(8'h05, 1'b1);
    rc(8'h0C, 8'h00);
    ev(8'h40);
    rc(8'h04, 8'h03);
    wr(8'h05, 8'h00);
    rc(8'h0C, 8'h00);
    rc(8'h04, 8'h00);
    rc(8'h05, 8'h00);
    wr(8'h0A, 8'hFF);
    idleReq <= 1'b1;
    repeat (15) @(posedge core_clk);
    rc(8'h0A, 8'h00);
    repeat (20) @(posedge core_clk);
    rc(8'h0A, 8'h40);
    idleReq <= 1'b0;
    repeat (8) @(posedge core_clk);
    rc(8'h0A, 8'h60);
    chk("wakeAsync", 16'h0001, {15'h0000, wakeAsync});
    w = 8'($urandom);
    wr(8'h3A, w);
    wr(8'h3B, ~w);
    @(negedge core_clk);
    chk("padTrim", {~w, w}, padTrim);
    rc(8'h3B, ~w);
    final_report();
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    nErrors++;
    final_report();
  end
endmodule // tb_usb_device_interrupt_flags

// ---- bench/udif_flags_monitor.sv ----
// concurrent checks on the ports of the interrupt flag block
module udif_flags_monitor
  import udif_pkg::*;
#(
  parameter int SUSPEND_CNT = SUSPEND_CYCLES,
  parameter int QUEUE_DEPTH = 32
)(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       frameStartRx,
  input wire logic       stallSent,
  input wire logic       setupDone,
  input wire logic       queuePush,
  input wire logic [1:0] irqLevel,
  input wire logic       irqRequest
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // sticky flags; a software write in between could legally clear them
  property p_set(ev, logic [7:0] a, int b);
    ev ##1 !regWrite |=> regAddr != a || regRdata[b];
  endproperty
  a_level_zero_gate:
    assert property (irqLevel == 2'b00 |-> !irqRequest) else $error("request at level zero");
  a_level_field_load:
    assert property (regWrite && regAddr == 8'h06 |=> {6'h00, irqLevel} == ($past(regWdata) & 8'h03))
    else $error("level field not loaded");
  a_frame_flag_set:
    assert property (p_set(frameStartRx, 8'h0B, 7)) else $error("frame flag not set");
  a_stall_flag_set:
    assert property (p_set(stallSent, 8'h0B, 0)) else $error("stall flag not set");
  a_setup_flag_set:
    assert property (p_set(setupDone, 8'h0D, 0)) else $error("setup flag not set");
  a_push_flag_set:
    assert property (p_set(queuePush, 8'h0D, 1)) else $error("transfer flag not set");
  a_set_alias_a:
    assert property (regWrite && regAddr == 8'h0B |=>
      regAddr != 8'h0B || (regRdata & $past(regWdata)) == $past(regWdata))
    else $error("set alias lost a bit");
  a_queue_flush_clear:
    assert property ((regWrite && (regAddr == 8'h04 || regAddr == 8'h05) && !queuePush)
      ##1 !queuePush |=> regAddr != 8'h0C || !regRdata[1]) else $error("flush kept flag");
  c_request: cover property (irqRequest);
  c_push: cover property (queuePush);
  c_set_write: cover property (regWrite && regAddr == 8'h0B);
endmodule // udif_flags_monitor
bind udif_flags udif_flags_monitor #(.SUSPEND_CNT(SUSPEND_CNT), .QUEUE_DEPTH(QUEUE_DEPTH))
  i_mon (
  .core_clk     (core_clk),
  .rst_n        (rst_n),
  .regAddr      (regAddr),
  .regWrite     (regWrite),
  .regWdata     (regWdata),
  .regRdata     (regRdata),
  .frameStartRx (frameStartRx),
  .stallSent    (stallSent),
  .setupDone    (setupDone),
  .queuePush    (queuePush),
  .irqLevel     (irqLevel),
  .irqRequest   (irqRequest)
);

// ---- bench/udif_link_model.sv ----
// link-side partner model: registers bench requests one cycle later onto the event lines and bus idle
module udif_link_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] evReq,
  input  wire logic       idleReq,
  output logic            busIdle,
  output logic            frameStartRx,
  output logic            queuePush,
  output logic            setupDone,
  output logic            busResetSeen,
  output logic            isoChecksumErr,
  output logic            inNoData,
  output logic            outNotReady,
  output logic            stallSent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] lineReg;
  assign {busIdle, frameStartRx, queuePush, setupDone, busResetSeen} = lineReg[8:4];
  assign {isoChecksumErr, inNoData, outNotReady, stallSent} = lineReg[3:0];
  // starts quiet so the block never sees an unknown event while in reset
  initial lineReg = 9'h000;
  always @(posedge core_clk)
    lineReg <= {idleReq, evReq};
endmodule // udif_link_model

// ---- core/udif_flags.sv ----
// usb device interrupt enable, sticky flag, alias and pad trim register logic
// ==========================================================
module udif_flags
  import udif_pkg::*;
#(
  parameter int SUSPEND_CNT = SUSPEND_CYCLES,
  parameter int QUEUE_DEPTH = 32
)(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       busIdle,
  input  wire logic       frameStartRx,
  input  wire logic       busResetSeen,
  input  wire logic       isoChecksumErr,
  input  wire logic       inNoData,
  input  wire logic       outNotReady,
  input  wire logic       stallSent,
  input  wire logic       setupDone,
  input  wire logic       queuePush,
  input  wire logic       queueEnable,
  output logic      [1:0] irqLevel,
  output logic            irqRequest,
  output logic            wakeAsync,
  output logic     [15:0] padTrim
);

  // ==========================================================
  // declarations
  logic [7:0]  enA_reg;
  logic [7:0]  enA_next;
  logic [7:0]  enB_reg;
  logic [7:0]  enB_next;
  logic [7:0]  flagsA_reg;
  logic [7:0]  flagsA_next;
  logic [7:0]  flagsB_reg;
  logic [7:0]  flagsB_next;
  logic [7:0]  trimLo_reg;
  logic [7:0]  trimLo_next;
  logic [7:0]  trimHi_reg;
  logic [7:0]  trimHi_next;
  logic [4:0]  wp_reg;
  logic [4:0]  wp_next;
  logic [4:0]  rp_reg;
  logic [4:0]  rp_next;
  logic [31:0] idleCnt_reg;
  logic [31:0] idleCnt_next;
  logic [2:0]  idleSync_reg;
  logic [2:0]  idleSync_next;
  logic        suspended_reg;
  logic        suspended_next;
  logic        wakeLatch_reg;
  logic [2:0]  wakeSync_reg;
  logic [2:0]  wakeSync_next;
  logic        wakeSeen_reg;
  logic        wakeSeen_next;
  logic        wrA;
  logic        wrB;
  logic        wrTrimLo;
  logic        wrTrimHi;
  logic        wrSetA;
  logic        wrClrA;
  logic        wrSetB;
  logic        wrClrB;
  logic        ptrWrite;
  logic        rpRead;
  logic        idleNow;
  logic        idleStable;
  logic        pending;
  logic [4:0]  depthMask;
  logic [7:0]  evtA;
  logic        wakeRise;
  logic        anyA;
  logic        anyB;

  // ==========================================================
  // decode
  assign wrSetA   = regWrite && regAddr == OFS_FLAGS_A_SET;
  assign wrClrA   = regWrite && regAddr == OFS_FLAGS_A_CLR;
  assign wrSetB   = regWrite && regAddr == OFS_FLAGS_B_SET;
  assign wrClrB   = regWrite && regAddr == OFS_FLAGS_B_CLR;
  assign wrA      = regWrite && regAddr == OFS_IRQ_EN_A;
  assign wrB      = regWrite && regAddr == OFS_IRQ_EN_B;
  assign wrTrimLo = regWrite && regAddr == OFS_TRIM_LOW;
  assign wrTrimHi = regWrite && regAddr == OFS_TRIM_HIGH;
  // the written pointer value is dropped: any write only flushes the queue
  assign ptrWrite = regWrite && (regAddr == OFS_QUEUE_WP || regAddr == OFS_QUEUE_RP);
  assign rpRead   = regRead && regAddr == OFS_QUEUE_RP;
  assign depthMask = 5'(QUEUE_DEPTH - 1);

  // ==========================================================
  // suspend detection: bus idle pin through three flops
  // a level counts only once the second and third flops agree, so one bad sample is ignored
  assign idleStable = idleSync_reg[1] == idleSync_reg[2];
  assign idleNow    = idleSync_reg[2];

  // resume: latched without clock on bus activity while suspended
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      idleSync_reg <= 3'h0;
    else
      idleSync_reg <= idleSync_next;
  end

  // the latch is set by the bus itself so it works with the core clock stopped
  // limitation: it only falls again on a bus edge seen after suspend has ended
  always_ff @(negedge busIdle or negedge rst_n)
  begin
    if (!rst_n)
      wakeLatch_reg <= 1'b0;
    else
      wakeLatch_reg <= suspended_reg;
  end

  assign wakeAsync = wakeLatch_reg;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wakeSync_reg <= 3'h0;
    else
      wakeSync_reg <= wakeSync_next;
  end

  assign wakeRise = wakeSync_reg[1] && wakeSync_reg[2] && !wakeSeen_reg;

  // ==========================================================
  // next-state logic
  always_comb
  begin
    idleCnt_next   = idleCnt_reg;
    suspended_next = suspended_reg;
    wakeSeen_next  = wakeSync_reg[1] == wakeSync_reg[2] ? wakeSync_reg[2] : wakeSeen_reg;
    idleSync_next  = {idleSync_reg[1:0], busIdle};
    wakeSync_next  = {wakeSync_reg[1:0], wakeLatch_reg};
    evtA           = 8'h00;
    if (idleStable && idleNow)
    begin
      // the count saturates so one idle period raises the suspend flag once
      if (idleCnt_reg < 32'(SUSPEND_CNT))
        idleCnt_next = idleCnt_reg + 32'h1;
      if (idleCnt_reg == 32'(SUSPEND_CNT - 1))
      begin
        evtA[BIT_IDLE_SUSPEND] = 1'b1;
        suspended_next = 1'b1;
      end
    end
    else if (idleStable)
    begin
      idleCnt_next   = 32'h0;
      suspended_next = 1'b0;
    end
    evtA[BIT_FRAME_START]   = frameStartRx;
    evtA[BIT_WAKE_ACTIVITY] = wakeRise;
    evtA[BIT_BUS_RESET]     = busResetSeen;
    evtA[BIT_ISO_CHECKSUM]  = isoChecksumErr;
    evtA[BIT_IN_NO_DATA]    = inNoData;
    evtA[BIT_OUT_NOT_READY] = outNotReady;
    evtA[BIT_STALL_SENT]    = stallSent;

    // hardware set wins over a same-cycle software clear
    flagsA_next = flagsA_reg;
    if (wrClrA)
      flagsA_next = flagsA_next & ~regWdata;
    if (wrSetA)
      flagsA_next = flagsA_next | regWdata;
    flagsA_next = flagsA_next | evtA;

    // completion queue pointers
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (ptrWrite)
    begin
      wp_next = RST_QUEUE_PTR;
      rp_next = RST_QUEUE_PTR;
    end
    else
    begin
      if (queuePush)
        wp_next = (wp_reg + 5'h1) & depthMask;
      // an empty queue ignores the read so the read pointer never passes the write pointer
      if (rpRead && queueEnable && rp_reg != wp_reg)
        rp_next = (rp_reg + 5'h1) & depthMask;
    end
    pending = wp_next != rp_next;

    flagsB_next = flagsB_reg;
    if (wrClrB)
      flagsB_next = flagsB_next & ~regWdata;
    if (wrSetB)
      flagsB_next = flagsB_next | regWdata;
    // in queue mode the transfer flag follows occupancy, so a software set is undone while empty
    if (ptrWrite || (queueEnable && !pending))
      flagsB_next[BIT_XFER_DONE] = 1'b0;
    if (queuePush || (queueEnable && pending))
      flagsB_next[BIT_XFER_DONE] = 1'b1;
    if (setupDone)
      flagsB_next[BIT_SETUP_DONE] = 1'b1;
    flagsB_next = flagsB_next & MASK_FLAGS_B;

    enA_next    = wrA ? (regWdata & MASK_IRQ_EN_A) : enA_reg;
    enB_next    = wrB ? (regWdata & MASK_IRQ_EN_B) : enB_reg;
    // the trim bytes load independently, so software may write them in either order
    trimLo_next = wrTrimLo ? regWdata : trimLo_reg;
    trimHi_next = wrTrimHi ? regWdata : trimHi_reg;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enA_reg       <= RST_IRQ_EN_A;
      enB_reg       <= RST_IRQ_EN_B;
      flagsA_reg    <= RST_FLAGS_A;
      flagsB_reg    <= RST_FLAGS_B;
      trimLo_reg    <= RST_TRIM;
      trimHi_reg    <= RST_TRIM;
      wp_reg        <= RST_QUEUE_PTR;
      rp_reg        <= RST_QUEUE_PTR;
      idleCnt_reg   <= 32'h0;
      suspended_reg <= 1'b0;
      wakeSeen_reg  <= 1'b0;
    end
    else
    begin
      enA_reg       <= enA_next;
      enB_reg       <= enB_next;
      flagsA_reg    <= flagsA_next;
      flagsB_reg    <= flagsB_next;
      trimLo_reg    <= trimLo_next;
      trimHi_reg    <= trimHi_next;
      wp_reg        <= wp_next;
      rp_reg        <= rp_next;
      idleCnt_reg   <= idleCnt_next;
      suspended_reg <= suspended_next;
      wakeSeen_reg  <= wakeSeen_next;
    end
  end

  // ==========================================================
  // interrupt request
  // left unregistered so the request drops in the cycle its last flag clears
  always_comb
  begin
    anyA = (enA_reg[BIT_FRAME_START_EN] && flagsA_reg[BIT_FRAME_START])
        || (enA_reg[BIT_BUS_EVENT_EN] && |flagsA_reg[BIT_IDLE_SUSPEND:BIT_BUS_RESET])
        || (enA_reg[BIT_BUS_ERROR_EN] && |flagsA_reg[BIT_ISO_CHECKSUM:BIT_OUT_NOT_READY])
        || (enA_reg[BIT_STALL_EN] && flagsA_reg[BIT_STALL_SENT]);
    anyB = (enB_reg[BIT_XFER_DONE_EN] && flagsB_reg[BIT_XFER_DONE])
        || (enB_reg[BIT_SETUP_DONE_EN] && flagsB_reg[BIT_SETUP_DONE]);
  end

  assign irqLevel   = enA_reg[BIT_LEVEL_HI:0];
  assign irqRequest = (irqLevel != 2'h0) && (anyA || anyB);
  assign padTrim    = {trimHi_reg, trimLo_reg};

  // ==========================================================
  // read mux; both aliases read the same flags
  // reserved bits read as zero because the masks are applied on the way in
  always_comb
  begin
    unique case (regAddr)
      OFS_IRQ_EN_A:                     regRdata = enA_reg;
      OFS_IRQ_EN_B:                     regRdata = enB_reg;
      OFS_FLAGS_A_CLR, OFS_FLAGS_A_SET: regRdata = flagsA_reg;
      OFS_FLAGS_B_CLR, OFS_FLAGS_B_SET: regRdata = flagsB_reg;
      OFS_QUEUE_WP:                     regRdata = {3'h0, wp_reg};
      OFS_QUEUE_RP:                     regRdata = {3'h0, rp_reg};
      OFS_TRIM_LOW:                     regRdata = trimLo_reg;
      OFS_TRIM_HIGH:                    regRdata = trimHi_reg;
      default:                          regRdata = 8'h00;
    endcase
  end

endmodule // udif_flags

// ---- core/udif_pkg.sv ----
// package for the usb device interrupt flag block: offsets, fields, resets, timing
package udif_pkg;

  // ==========================================================
  // register offsets (byte addresses on the i/o register port)
  localparam logic [7:0] OFS_IRQ_EN_A    = 8'h06;
  localparam logic [7:0] OFS_IRQ_EN_B    = 8'h07;
  localparam logic [7:0] OFS_FLAGS_A_CLR = 8'h0A;
  localparam logic [7:0] OFS_FLAGS_A_SET = 8'h0B;
  localparam logic [7:0] OFS_FLAGS_B_CLR = 8'h0C;
  localparam logic [7:0] OFS_FLAGS_B_SET = 8'h0D;
  localparam logic [7:0] OFS_QUEUE_WP    = 8'h04;
  localparam logic [7:0] OFS_QUEUE_RP    = 8'h05;
  localparam logic [7:0] OFS_TRIM_LOW    = 8'h3A;
  localparam logic [7:0] OFS_TRIM_HIGH   = 8'h3B;

  // ==========================================================
  // field positions
  localparam int BIT_FRAME_START_EN  = 7;
  localparam int BIT_BUS_EVENT_EN    = 6;
  localparam int BIT_BUS_ERROR_EN    = 5;
  localparam int BIT_STALL_EN        = 4;
  localparam int BIT_LEVEL_HI        = 1;
  localparam int BIT_XFER_DONE_EN    = 1;
  localparam int BIT_SETUP_DONE_EN   = 0;
  localparam int BIT_FRAME_START     = 7;
  localparam int BIT_IDLE_SUSPEND    = 6;
  localparam int BIT_WAKE_ACTIVITY   = 5;
  localparam int BIT_BUS_RESET       = 4;
  localparam int BIT_ISO_CHECKSUM    = 3;
  localparam int BIT_IN_NO_DATA      = 2;
  localparam int BIT_OUT_NOT_READY   = 1;
  localparam int BIT_STALL_SENT      = 0;
  localparam int BIT_XFER_DONE       = 1;
  localparam int BIT_SETUP_DONE      = 0;

  // writable bit masks; reserved bits read as zero
  localparam logic [7:0] MASK_IRQ_EN_A = 8'hF3;
  localparam logic [7:0] MASK_IRQ_EN_B = 8'h03;
  localparam logic [7:0] MASK_FLAGS_B  = 8'h03;
  localparam logic [4:0] QUEUE_PTR_MASK = 5'h1F;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_IRQ_EN_A = 8'h00;
  localparam logic [7:0] RST_IRQ_EN_B = 8'h00;
  localparam logic [7:0] RST_FLAGS_A  = 8'h00;
  localparam logic [7:0] RST_FLAGS_B  = 8'h00;
  localparam logic [7:0] RST_TRIM     = 8'h00;
  localparam logic [4:0] RST_QUEUE_PTR = 5'h00;

  // ==========================================================
  // timing
  localparam int CLK_FREQ_HZ     = 125000000;
  localparam int SUSPEND_IDLE_MS = 3;
  localparam int SUSPEND_CYCLES  = (CLK_FREQ_HZ / 1000) * SUSPEND_IDLE_MS;

endpackage : udif_pkg
